// ===== nvw_cfg.svh
// Constants for the data EEPROM write and erase controller
`ifndef NVW_CFG_SVH
`define NVW_CFG_SVH
`define NVW_SEL_CTRL 3'h0
`define NVW_SEL_AHI 3'h1
`define NVW_SEL_ALO 3'h2
`define NVW_SEL_DATA 3'h3
`define NVW_SEL_IRQ 3'h4
`define NVW_B_ERASE_ENABLE 6
`define NVW_B_ER 5
`define NVW_B_MODE 4
`define NVW_B_WRITE_ENABLE_BIT 3
`define NVW_B_WR 2
`define NVW_CTRL_RST 8'h00
`define NVW_ADDR_W 10
`define NVW_MEM_DEPTH 1024
`define NVW_PAGE_BYTES 16
`define NVW_CLK_NS 40
`define NVW_TMR_NS 1000
`define NVW_TICK_DIV ((`NVW_TMR_NS + `NVW_CLK_NS - 1) / `NVW_CLK_NS)
`define NVW_OP_TICKS 100
`define NVW_REG_ADDR 5'h00
`define NVW_REG_DATA 5'h04
`define NVW_REG_CMD 5'h08
`define NVW_REG_STAT 5'h0c
`define NVW_REG_IRQEN 5'h10
`define NVW_REG_MEMRD 5'h14
`define NVW_CMD_BYTE_WR 2'h1
`define NVW_CMD_PAGE_ER 2'h2
`define NVW_CMD_PAGE_WR 2'h3
`endif

// ===== nvw_pkg.sv
// Types shared by both ends of the EEPROM controller
package nvw_pkg;
  typedef logic [7:0] nvw_byte_t;
  typedef logic [2:0] nvw_sel_t;
  typedef enum logic {NVW_D_IDLE, NVW_D_BUSY} nvw_dst_t;
  typedef enum logic [3:0] {
    NVW_H_IDLE, NVW_H_AHI, NVW_H_ALO, NVW_H_DAT, NVW_H_FLG,
    NVW_H_GOFF, NVW_H_MODE, NVW_H_EN, NVW_H_GO, NVW_H_GON, NVW_H_WAIT
  } nvw_hst_t;
endpackage : nvw_pkg

// ===== nvw_if.sv
// Special-function register link between core and EEPROM controller
`timescale 1ns/10ps
`default_nettype none
`include "nvw_cfg.svh"
interface nvw_if;
  import nvw_pkg::*;
  logic sfr_wr;
  nvw_sel_t sfr_sel;
  nvw_byte_t sfr_wdata;
  logic global_irq_enable;
  logic nv_irq_enable;
  logic mf_irq_enable;
  logic stack_full;
  logic int_ack;
  logic [`NVW_ADDR_W-1:0] mem_raddr;
  nvw_byte_t nv_control_reg;
  nvw_byte_t nv_addr_low;
  logic nv_irq_flag;
  logic mf_irq_flag;
  logic int_req;
  nvw_byte_t mem_rdata;
  modport dev (
    input sfr_wr, sfr_sel, sfr_wdata, global_irq_enable, nv_irq_enable,
    input mf_irq_enable, stack_full, int_ack, mem_raddr,
    output nv_control_reg, nv_addr_low, nv_irq_flag, mf_irq_flag,
    output int_req, mem_rdata
  );
  modport host (
    output sfr_wr, sfr_sel, sfr_wdata, global_irq_enable, nv_irq_enable,
    output mf_irq_enable, stack_full, int_ack, mem_raddr,
    input nv_control_reg, nv_addr_low, nv_irq_flag, mf_irq_flag,
    input int_req, mem_rdata
  );
endinterface : nvw_if
`default_nettype wire

// ===== nvw_dev.sv
// Data EEPROM controller: registers, page buffer, cycle timer, array
// Contract
// - Erase-start bit clears when erase ends
// - Erase-enable bit clears when erase ends
// - Erased page reads back all zero
// - Mode clear: single byte write from registers
// - Write starts only on enable then start
// - Start without enable begins no write
// - Timer times cycle; start bit self-clears
// - Write-enable bit clears when write ends
// - Byte write erases the byte first
// - Mode set: page write up to sixteen
// - Buffer empties at reset and enable fall
// - Page bits fixed; byte bits increment
// - In-page address saturates; later writes ignored
// - Page mode data write fills buffer
// - Cycle end sets both request flags
// - Vector needs all enables, stack free
// - Service clears multi-function flag only
// - Power-on clears write-enable bit
// - Core masks interrupts around activation
// - No idle or sleep during operation
// - Page erased before page write
// - Erase starts only on enable then start
// - Page erase dummy writes advance address
`timescale 1ns/10ps
`default_nettype none
`include "nvw_cfg.svh"
module nvw_dev #(
  parameter int OP_TICKS = `NVW_OP_TICKS
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic idle_in,
  output logic busy_out,
  nvw_if.dev bus
);
  import nvw_pkg::*;

  localparam logic [7:0] DIV_LAST = 8'(`NVW_TICK_DIV - 1);
  localparam logic [15:0] OP_LAST = 16'(OP_TICKS - 1);
  localparam int PB = `NVW_PAGE_BYTES;

  function automatic logic wr_to(input logic wr, input nvw_sel_t sel,
                                 input nvw_sel_t code);
    return wr && (sel == code);
  endfunction : wr_to

  logic [7:0] div_r, div_nxt;
  logic tick_r, tick_nxt;

  nvw_dst_t st_r, st_nxt;
  nvw_byte_t ctrl_r, ctrl_nxt;
  nvw_byte_t ahi_r, ahi_nxt;
  nvw_byte_t alo_r, alo_nxt;
  nvw_byte_t data_r, data_nxt;
  nvw_byte_t buf_r [0:PB-1];
  nvw_byte_t buf_nxt [0:PB-1];
  logic [PB-1:0] tag_r, tag_nxt;
  logic full_r, full_nxt;
  logic arm_w_r, arm_w_nxt;
  logic arm_e_r, arm_e_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic nvf_r, nvf_nxt;
  logic mff_r, mff_nxt;
  logic irq_r, irq_nxt;
  logic busy_r, busy_nxt;
  nvw_byte_t rd_r, rd_nxt;
  nvw_byte_t mem_r [0:`NVW_MEM_DEPTH-1];
  nvw_byte_t mem_nxt [0:`NVW_MEM_DEPTH-1];

  logic w_ctl, w_ahi, w_alo, w_dat, w_irq;
  logic go_w, go_e, done;
  logic [3:0] idx;
  logic [`NVW_ADDR_W-1:0] addr;
  logic [`NVW_ADDR_W-5:0] page;
  nvw_byte_t wd;

  assign wd = bus.sfr_wdata;
  assign w_ctl = wr_to(bus.sfr_wr, bus.sfr_sel, `NVW_SEL_CTRL);
  assign w_ahi = wr_to(bus.sfr_wr, bus.sfr_sel, `NVW_SEL_AHI);
  assign w_alo = wr_to(bus.sfr_wr, bus.sfr_sel, `NVW_SEL_ALO);
  assign w_dat = wr_to(bus.sfr_wr, bus.sfr_sel, `NVW_SEL_DATA);
  assign w_irq = wr_to(bus.sfr_wr, bus.sfr_sel, `NVW_SEL_IRQ);
  assign idx = alo_r[3:0];
  assign addr = `NVW_ADDR_W'({ahi_r, alo_r});
  assign page = addr[`NVW_ADDR_W-1:4];
  // Start honoured only if the enable rose on a control write in the cycle just before
  assign go_w = w_ctl && arm_w_r && ctrl_r[`NVW_B_WRITE_ENABLE_BIT] && wd[`NVW_B_WRITE_ENABLE_BIT]
                && wd[`NVW_B_WR] && !wd[`NVW_B_ER];
  assign go_e = w_ctl && arm_e_r && ctrl_r[`NVW_B_ERASE_ENABLE] && wd[`NVW_B_ERASE_ENABLE]
                && wd[`NVW_B_ER] && !wd[`NVW_B_WR];

  // Slow timer clock as an enable pulse
  always_comb begin
    div_nxt = (div_r == DIV_LAST) ? 8'h00 : div_r + 8'h01;
    tick_nxt = (div_r == DIV_LAST);
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  always_comb begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    ahi_nxt = ahi_r;
    alo_nxt = alo_r;
    data_nxt = data_r;
    buf_nxt = buf_r;
    tag_nxt = tag_r;
    full_nxt = full_r;
    arm_w_nxt = 1'b0;
    arm_e_nxt = 1'b0;
    cnt_nxt = cnt_r;
    mem_nxt = mem_r;
    done = 1'b0;
    case (st_r)
      NVW_D_IDLE: begin
        if (w_ctl) begin
          ctrl_nxt = `NVW_CTRL_RST;
          ctrl_nxt[`NVW_B_ERASE_ENABLE] = wd[`NVW_B_ERASE_ENABLE];
          ctrl_nxt[`NVW_B_MODE] = wd[`NVW_B_MODE];
          ctrl_nxt[`NVW_B_WRITE_ENABLE_BIT] = wd[`NVW_B_WRITE_ENABLE_BIT];
          arm_w_nxt = wd[`NVW_B_WRITE_ENABLE_BIT] && !ctrl_r[`NVW_B_WRITE_ENABLE_BIT];
          arm_e_nxt = wd[`NVW_B_ERASE_ENABLE] && !ctrl_r[`NVW_B_ERASE_ENABLE];
          if (go_w || go_e) begin
            ctrl_nxt[`NVW_B_WR] = go_w;
            ctrl_nxt[`NVW_B_ER] = go_e;
            st_nxt = NVW_D_BUSY;
            cnt_nxt = 16'h0000;
          end
        end
        if (w_ahi) begin
          ahi_nxt = wd;
        end
        if (w_alo) begin
          alo_nxt = wd;
          full_nxt = 1'b0;
        end
        // Past the last slot the write is dropped entirely
        if (w_dat && !(ctrl_r[`NVW_B_MODE] && full_r)) begin
          data_nxt = wd;
          if (ctrl_r[`NVW_B_MODE]) begin
            buf_nxt[idx] = wd;
            tag_nxt[idx] = 1'b1;
            if (idx == 4'hf) begin
              full_nxt = 1'b1;
            end else begin
              alo_nxt[3:0] = idx + 4'h1;
            end
          end
        end
      end
      NVW_D_BUSY: begin
        if (idle_in) begin
          // Entering idle kills the cycle; the array is left untouched
          ctrl_nxt = ctrl_r & ~8'h6c;
          st_nxt = NVW_D_IDLE;
        end else if (tick_r) begin
          cnt_nxt = cnt_r + 16'h0001;
          if (cnt_r == OP_LAST) begin
            done = 1'b1;
            st_nxt = NVW_D_IDLE;
            ctrl_nxt[`NVW_B_ER] = 1'b0;
            ctrl_nxt[`NVW_B_ERASE_ENABLE] = 1'b0;
            ctrl_nxt[`NVW_B_WR] = 1'b0;
            ctrl_nxt[`NVW_B_WRITE_ENABLE_BIT] = 1'b0;
            if (ctrl_r[`NVW_B_ER]) begin
              if (ctrl_r[`NVW_B_MODE]) begin
                for (int i = 0; i < PB; i++) begin
                  mem_nxt[{page, 4'(i)}] = 8'h00;
                end
              end else begin
                mem_nxt[addr] = 8'h00;
              end
            end else if (ctrl_r[`NVW_B_MODE]) begin
              for (int i = 0; i < PB; i++) begin
                if (tag_r[i]) begin
                  mem_nxt[{page, 4'(i)}] = buf_r[i];
                end
              end
            end else begin
              // Old byte is replaced whole: erase folded into the write
              mem_nxt[addr] = data_r;
            end
          end
        end
      end
      default: begin
        st_nxt = NVW_D_IDLE;
      end
    endcase
    if ((ctrl_r[`NVW_B_WRITE_ENABLE_BIT] && !ctrl_nxt[`NVW_B_WRITE_ENABLE_BIT]) ||
        (ctrl_r[`NVW_B_ERASE_ENABLE] && !ctrl_nxt[`NVW_B_ERASE_ENABLE])) begin
      for (int i = 0; i < PB; i++) begin
        buf_nxt[i] = 8'h00;
      end
      tag_nxt = '0;
    end
  end

  always_comb begin
    nvf_nxt = nvf_r;
    mff_nxt = mff_r;
    if (w_irq && !wd[0]) begin
      nvf_nxt = 1'b0;
    end
    if (bus.int_ack) begin
      mff_nxt = 1'b0;
    end
    if (done) begin
      nvf_nxt = 1'b1;
      mff_nxt = 1'b1;
    end
    irq_nxt = bus.global_irq_enable && bus.nv_irq_enable &&
              bus.mf_irq_enable && nvf_nxt && mff_nxt &&
              !bus.stack_full && !bus.int_ack;
    busy_nxt = (st_nxt == NVW_D_BUSY);
    rd_nxt = mem_r[bus.mem_raddr];
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= NVW_D_IDLE;
      ctrl_r <= `NVW_CTRL_RST;
      ahi_r <= 8'h00;
      alo_r <= 8'h00;
      data_r <= 8'h00;
      tag_r <= '0;
      full_r <= 1'b0;
      arm_w_r <= 1'b0;
      arm_e_r <= 1'b0;
      cnt_r <= 16'h0000;
      nvf_r <= 1'b0;
      mff_r <= 1'b0;
      irq_r <= 1'b0;
      busy_r <= 1'b0;
      rd_r <= 8'h00;
      for (int i = 0; i < PB; i++) begin
        buf_r[i] <= 8'h00;
      end
      for (int i = 0; i < `NVW_MEM_DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      ahi_r <= ahi_nxt;
      alo_r <= alo_nxt;
      data_r <= data_nxt;
      tag_r <= tag_nxt;
      full_r <= full_nxt;
      arm_w_r <= arm_w_nxt;
      arm_e_r <= arm_e_nxt;
      cnt_r <= cnt_nxt;
      nvf_r <= nvf_nxt;
      mff_r <= mff_nxt;
      irq_r <= irq_nxt;
      busy_r <= busy_nxt;
      rd_r <= rd_nxt;
      buf_r <= buf_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign bus.nv_control_reg = ctrl_r;
  assign bus.nv_addr_low = alo_r;
  assign bus.nv_irq_flag = nvf_r;
  assign bus.mf_irq_flag = mff_r;
  assign bus.int_req = irq_r;
  assign bus.mem_rdata = rd_r;
  assign busy_out = busy_r;
endmodule : nvw_dev
`default_nettype wire

// ===== nvw_host.sv
// Core-side sequencer driving the EEPROM registers from Avalon-MM
`timescale 1ns/10ps
`default_nettype none
`include "nvw_cfg.svh"
module nvw_host (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stack_full_in,
  output logic sleep_ok_out,
  nvw_if.host bus
);
  import nvw_pkg::*;

  nvw_hst_t st_r, st_nxt;
  logic wt_r, wt_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [15:0] addr_r, addr_nxt;
  nvw_byte_t data_r, data_nxt;
  logic [1:0] op_r, op_nxt;
  logic [2:0] ien_r, ien_nxt;
  logic mask_r, mask_nxt;
  logic wr_r, wr_nxt;
  nvw_sel_t sel_r, sel_nxt;
  nvw_byte_t wd_r, wd_nxt;
  logic ack_r, ack_nxt;
  logic [`NVW_ADDR_W-1:0] ra_r, ra_nxt;
  logic ref_r, ref_nxt;
  logic srv_r, srv_nxt;
  logic [5:0] epg_r, epg_nxt;
  logic eok_r, eok_nxt;
  logic slp_r, slp_nxt;
  logic req, acc, act, mode, dbusy;

  assign req = avs_read || avs_write;
  assign acc = req && wt_r && (avs_read || st_r == NVW_H_IDLE);
  assign act = req && !wt_r;
  assign mode = (op_r != `NVW_CMD_BYTE_WR);
  assign dbusy = bus.nv_control_reg[`NVW_B_WR] ||
                 bus.nv_control_reg[`NVW_B_ER];

  always_comb begin
    st_nxt = st_r;
    wt_nxt = !acc;
    rd_nxt = rd_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    op_nxt = op_r;
    ien_nxt = ien_r;
    mask_nxt = mask_r;
    wr_nxt = 1'b0;
    sel_nxt = sel_r;
    wd_nxt = wd_r;
    ack_nxt = bus.int_req && !ack_r;
    ra_nxt = ra_r;
    ref_nxt = ref_r;
    srv_nxt = srv_r || (bus.int_req && !ack_r);
    epg_nxt = epg_r;
    eok_nxt = eok_r;
    if (acc) begin
      case (avs_address)
        `NVW_REG_ADDR: rd_nxt = {16'h0000, addr_r};
        `NVW_REG_STAT: rd_nxt = {27'h000_0000, srv_r, ref_r,
                                 bus.mf_irq_flag, bus.nv_irq_flag,
                                 dbusy || st_r != NVW_H_IDLE};
        `NVW_REG_IRQEN: rd_nxt = {29'h0000_0000, ien_r};
        `NVW_REG_MEMRD: rd_nxt = {24'h00_0000, bus.mem_rdata};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
    if (act && avs_write) begin
      case (avs_address)
        `NVW_REG_ADDR: begin
          addr_nxt = avs_writedata[15:0];
          st_nxt = NVW_H_AHI;
        end
        `NVW_REG_DATA: begin
          data_nxt = avs_writedata[7:0];
          st_nxt = NVW_H_DAT;
        end
        `NVW_REG_CMD: begin
          op_nxt = avs_writedata[1:0];
          ref_nxt = 1'b0;
          // Page write is refused unless this page was erased last
          if (avs_writedata[1:0] == `NVW_CMD_PAGE_WR &&
              !(eok_r && epg_r == addr_r[9:4])) begin
            ref_nxt = 1'b1;
          end else if (avs_writedata[1:0] != 2'h0) begin
            st_nxt = NVW_H_GOFF;
          end
        end
        `NVW_REG_STAT: begin
          if (avs_writedata[1]) begin
            st_nxt = NVW_H_FLG;
          end
          // A service arriving with the clear still counts
          srv_nxt = (srv_r && !avs_writedata[4]) || (bus.int_req && !ack_r);
        end
        `NVW_REG_IRQEN: ien_nxt = avs_writedata[2:0];
        `NVW_REG_MEMRD: ra_nxt = avs_writedata[`NVW_ADDR_W-1:0];
        default: ;
      endcase
    end
    case (st_r)
      NVW_H_IDLE: ;
      NVW_H_AHI: begin
        {wr_nxt, sel_nxt, wd_nxt} = {1'b1, `NVW_SEL_AHI, addr_r[15:8]};
        st_nxt = NVW_H_ALO;
      end
      NVW_H_ALO: begin
        {wr_nxt, sel_nxt, wd_nxt} = {1'b1, `NVW_SEL_ALO, addr_r[7:0]};
        st_nxt = NVW_H_IDLE;
      end
      NVW_H_DAT: begin
        {wr_nxt, sel_nxt, wd_nxt} = {1'b1, `NVW_SEL_DATA, data_r};
        st_nxt = NVW_H_IDLE;
      end
      NVW_H_FLG: begin
        {wr_nxt, sel_nxt, wd_nxt} = {1'b1, `NVW_SEL_IRQ, 8'h00};
        st_nxt = NVW_H_IDLE;
      end
      NVW_H_GOFF: begin
        mask_nxt = 1'b1;
        st_nxt = NVW_H_MODE;
      end
      NVW_H_MODE: begin
        {wr_nxt, sel_nxt, wd_nxt} = {1'b1, `NVW_SEL_CTRL, 8'h00};
        wd_nxt[`NVW_B_MODE] = mode;
        st_nxt = NVW_H_EN;
      end
      NVW_H_EN: begin
        wr_nxt = 1'b1;
        wd_nxt[`NVW_B_ERASE_ENABLE] = (op_r == `NVW_CMD_PAGE_ER);
        wd_nxt[`NVW_B_WRITE_ENABLE_BIT] = (op_r != `NVW_CMD_PAGE_ER);
        st_nxt = NVW_H_GO;
      end
      NVW_H_GO: begin
        // Start lands on the very next cycle after the enable
        wr_nxt = 1'b1;
        wd_nxt[`NVW_B_ER] = (op_r == `NVW_CMD_PAGE_ER);
        wd_nxt[`NVW_B_WR] = (op_r != `NVW_CMD_PAGE_ER);
        st_nxt = NVW_H_GON;
      end
      NVW_H_GON: begin
        mask_nxt = 1'b0;
        st_nxt = NVW_H_WAIT;
      end
      NVW_H_WAIT: begin
        if (!dbusy) begin
          st_nxt = NVW_H_IDLE;
          if (op_r == `NVW_CMD_PAGE_ER) begin
            epg_nxt = addr_r[9:4];
            eok_nxt = 1'b1;
          end else begin
            eok_nxt = 1'b0;
          end
        end
      end
      default: st_nxt = NVW_H_IDLE;
    endcase
    slp_nxt = (st_nxt == NVW_H_IDLE) && !dbusy;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= NVW_H_IDLE;
      wt_r <= 1'b1;
      rd_r <= 32'h0000_0000;
      addr_r <= 16'h0000;
      data_r <= 8'h00;
      op_r <= 2'h0;
      ien_r <= 3'h0;
      mask_r <= 1'b0;
      wr_r <= 1'b0;
      sel_r <= `NVW_SEL_CTRL;
      wd_r <= 8'h00;
      ack_r <= 1'b0;
      ra_r <= '0;
      ref_r <= 1'b0;
      srv_r <= 1'b0;
      epg_r <= 6'h00;
      eok_r <= 1'b0;
      slp_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wt_r <= wt_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      op_r <= op_nxt;
      ien_r <= ien_nxt;
      mask_r <= mask_nxt;
      wr_r <= wr_nxt;
      sel_r <= sel_nxt;
      wd_r <= wd_nxt;
      ack_r <= ack_nxt;
      ra_r <= ra_nxt;
      ref_r <= ref_nxt;
      srv_r <= srv_nxt;
      epg_r <= epg_nxt;
      eok_r <= eok_nxt;
      slp_r <= slp_nxt;
    end
  end

  assign avs_readdata = rd_r;
  assign avs_waitrequest = wt_r;
  assign sleep_ok_out = slp_r;
  assign bus.sfr_wr = wr_r;
  assign bus.sfr_sel = sel_r;
  assign bus.sfr_wdata = wd_r;
  assign bus.global_irq_enable = ien_r[0] && !mask_r;
  assign bus.nv_irq_enable = ien_r[1];
  assign bus.mf_irq_enable = ien_r[2];
  assign bus.stack_full = stack_full_in;
  assign bus.int_ack = ack_r;
  assign bus.mem_raddr = ra_r;
endmodule : nvw_host
`default_nettype wire

// ===== nvw_props.sv
// Concurrent checks on the core-to-controller register link
`timescale 1ns/10ps
`default_nettype none
`include "nvw_cfg.svh"
module nvw_props #(
  parameter int OP_TICKS = `NVW_OP_TICKS
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sfr_wr,
  input wire nvw_pkg::nvw_sel_t sfr_sel,
  input wire nvw_pkg::nvw_byte_t sfr_wdata,
  input wire logic global_irq_enable,
  input wire logic nv_irq_enable,
  input wire logic mf_irq_enable,
  input wire logic stack_full,
  input wire logic int_ack,
  input wire nvw_pkg::nvw_byte_t nv_control_reg,
  input wire nvw_pkg::nvw_byte_t nv_addr_low,
  input wire logic nv_irq_flag,
  input wire logic mf_irq_flag,
  input wire logic int_req
);
  import nvw_pkg::*;
  // Timer ticks are free running, so the first one may come early
  localparam int RUN_LO = (OP_TICKS - 1) * 25;
  localparam int RUN_HI = OP_TICKS * 25 + 3;
  logic busy;
  logic [15:0] run_r;
  logic [15:0] run_nxt;
  assign busy = nv_control_reg[`NVW_B_WR] | nv_control_reg[`NVW_B_ER];
  always_comb run_nxt = busy ? run_r + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      run_r <= 16'h0000;
    else
      run_r <= run_nxt;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_wr_arm;
    $rose(nv_control_reg[`NVW_B_WRITE_ENABLE_BIT]) ##1 $rose(nv_control_reg[`NVW_B_WR]);
  endsequence
  property p_armed(logic en, logic go);
    $rose(go) |-> $past(en) && !$past(en, 2);
  endproperty
  chk_wr_armed: assert property (
    p_armed(nv_control_reg[`NVW_B_WRITE_ENABLE_BIT], nv_control_reg[`NVW_B_WR]))
    else $error("write start without arming");
  chk_er_armed: assert property (
    p_armed(nv_control_reg[`NVW_B_ERASE_ENABLE], nv_control_reg[`NVW_B_ER]))
    else $error("erase start without arming");
  chk_wr_holds: assert property (
    s_wr_arm |-> nv_control_reg[`NVW_B_WR] [*8])
    else $error("write cycle ended too soon");
  chk_wr_ends: assert property (
    $fell(nv_control_reg[`NVW_B_WR]) |->
    !nv_control_reg[`NVW_B_WRITE_ENABLE_BIT] && nv_irq_flag && mf_irq_flag)
    else $error("write end left enable or flags wrong");
  chk_er_ends: assert property (
    $fell(nv_control_reg[`NVW_B_ER]) |->
    !nv_control_reg[`NVW_B_ERASE_ENABLE] && nv_irq_flag && mf_irq_flag)
    else $error("erase end left enable or flags wrong");
  chk_run_length: assert property ($fell(busy) |->
    run_r >= RUN_LO && run_r <= RUN_HI) else $error("cycle length off");
  // Flags count in the cycle they are set; a service pulse drops the request
  chk_int_gate: assert property (int_req == (
    $past(global_irq_enable && nv_irq_enable && mf_irq_enable &&
    !stack_full && !int_ack) && nv_irq_flag && mf_irq_flag))
    else $error("interrupt request gating wrong");
  chk_ack_mf_only: assert property (int_ack && !busy &&
    !(sfr_wr && sfr_sel == `NVW_SEL_IRQ) |=>
    !mf_irq_flag && $stable(nv_irq_flag))
    else $error("service cleared wrong flag");
  chk_index_step: assert property (
    sfr_wr && sfr_sel == `NVW_SEL_DATA && nv_control_reg[`NVW_B_MODE] &&
    !busy |=> nv_addr_low == ($past(nv_addr_low[3:0]) == 4'hf ?
    $past(nv_addr_low) : $past(nv_addr_low) + 8'h01))
    else $error("in-page address step wrong");
  chk_write_enable_bit_by_write: assert property (
    $rose(nv_control_reg[`NVW_B_WRITE_ENABLE_BIT]) |->
    $past(sfr_wr && sfr_sel == `NVW_SEL_CTRL && sfr_wdata[`NVW_B_WRITE_ENABLE_BIT]))
    else $error("write enable set without a write");
  chk_gie_masked: assert property (
    sfr_wr && sfr_sel == `NVW_SEL_CTRL &&
    (sfr_wdata[`NVW_B_WR] || sfr_wdata[`NVW_B_ER]) |-> !global_irq_enable)
    else $error("start written with interrupts unmasked");
endmodule : nvw_props
`default_nettype wire

// ===== tb_data_eeprom_write_erase_ctrl.sv
// Bench: both controller ends joined, driven over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
`include "nvw_cfg.svh"
module tb_data_eeprom_write_erase_ctrl;
  import nvw_pkg::*;
  localparam int OPT = 2;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic stack_full = 1'h0;
  logic idle = 1'h0;
  logic busy;
  logic sleep_ok;
  logic [31:0] q = 32'h0000_0000;
  logic [31:0] ie = 32'h0000_0000;
  int n_errors = 0;
  int n_tests = 0;
  nvw_if link();
  nvw_dev #(.OP_TICKS(OPT)) i_nvw_dev (.ref_clk_in(clk), .resetn_in(resetn),
    .idle_in(idle), .busy_out(busy), .bus(link));
  nvw_host i_nvw_host (.ref_clk_in(clk), .resetn_in(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stack_full_in(stack_full),
    .sleep_ok_out(sleep_ok), .bus(link));
  nvw_props #(.OP_TICKS(OPT)) i_nvw_props (.ref_clk_in(clk),
    .resetn_in(resetn), .sfr_wr(link.sfr_wr), .sfr_sel(link.sfr_sel),
    .sfr_wdata(link.sfr_wdata), .global_irq_enable(link.global_irq_enable),
    .nv_irq_enable(link.nv_irq_enable), .mf_irq_enable(link.mf_irq_enable),
    .stack_full(link.stack_full), .int_ack(link.int_ack),
    .nv_control_reg(link.nv_control_reg), .nv_addr_low(link.nv_addr_low),
    .nv_irq_flag(link.nv_irq_flag), .mf_irq_flag(link.mf_irq_flag),
    .int_req(link.int_req));
  always #20 clk = ~clk;
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Request held until waitrequest is seen low at a rising edge
  task av(input logic rd, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 8000);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 8000)
      n_errors++;
  endtask : av
  task fill(input logic [9:0] base, input int n, input logic [7:0] v0);
    av(1'h0, `NVW_REG_ADDR, {22'h00_0000, base});
    for (int i = 0; i < n; i++)
      av(1'h0, `NVW_REG_DATA, {24'h00_0000, v0 + 8'(i)});
  endtask : fill
  // Host holds later writes while a sequence runs; poll busy as a backstop
  task cmd(input logic [1:0] c);
    av(1'h0, `NVW_REG_CMD, {30'h0000_0000, c});
    // Refused or running, busy and sleep-ok must disagree
    repeat (8) @(posedge clk);
    cmp("busy vs sleep ok", 32'h0000_0001, {31'h0, busy ^ sleep_ok});
    av(1'h0, `NVW_REG_IRQEN, ie);
    for (int k = 0; k < 100; k++) begin
      av(1'h1, `NVW_REG_STAT, 32'h0000_0000);
      if (q[0] === 1'h0)
        break;
    end
    cmp("control bits", 32'h0000_0000,
      {24'h00_0000, link.nv_control_reg & 8'h6c});
    cmp("idle flags", 32'h0000_0001, {30'h0, busy, sleep_ok});
  endtask : cmd
  task mem_chk(input logic [9:0] a, input logic [7:0] e);
    av(1'h0, `NVW_REG_MEMRD, {22'h00_0000, a});
    repeat (3) @(posedge clk);
    av(1'h1, `NVW_REG_MEMRD, 32'h0000_0000);
    cmp("array byte", {24'h00_0000, e}, q);
  endtask : mem_chk
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    cmp("control reset", 32'h0000_0000,
      {24'h00_0000, link.nv_control_reg});
    av(1'h1, `NVW_REG_STAT, 32'h0000_0000);
    cmp("status reset", 32'h0000_0000, q);
    // Multi-function enable off first, so no service hides the flags
    ie = 32'h0000_0003;
    av(1'h0, `NVW_REG_IRQEN, ie);
    fill(10'h123, 1, 8'ha5);
    cmd(`NVW_CMD_BYTE_WR);
    mem_chk(10'h123, 8'ha5);
    fill(10'h123, 1, 8'h5a);
    cmd(`NVW_CMD_BYTE_WR);
    mem_chk(10'h123, 8'h5a);
    av(1'h1, `NVW_REG_STAT, 32'h0000_0000);
    cmp("request flags", 32'h0000_0006, q & 32'h0000_0006);
    cmp("int request", 32'h0000_0000, {31'h0000_0000, link.int_req});
    stack_full <= 1'h1;
    ie = 32'h0000_0007;
    av(1'h0, `NVW_REG_IRQEN, ie);
    repeat (4) @(posedge clk);
    cmp("int request", 32'h0000_0000, {31'h0000_0000, link.int_req});
    stack_full <= 1'h0;
    repeat (6) @(posedge clk);
    av(1'h1, `NVW_REG_STAT, 32'h0000_0000);
    cmp("served and flags", 32'h0000_0012, q & 32'h0000_0016);
    av(1'h0, `NVW_REG_STAT, 32'h0000_0002);
    // Flag clear travels through the sequencer before it shows
    repeat (2) @(posedge clk);
    av(1'h1, `NVW_REG_STAT, 32'h0000_0000);
    cmp("nv flag cleared", 32'h0000_0000, q & 32'h0000_0002);
    fill(10'h120, 17, 8'h00);
    cmd(`NVW_CMD_PAGE_ER);
    mem_chk(10'h123, 8'h00);
    // Seventeenth byte lands on a saturated slot and must be dropped
    fill(10'h120, 17, 8'h10);
    cmp("in-page address", 32'h0000_002f,
      {24'h00_0000, link.nv_addr_low});
    cmd(`NVW_CMD_PAGE_WR);
    for (int i = 0; i < 16; i++)
      mem_chk(10'h120 + 10'(i), 8'h10 + 8'(i));
    // Nonzero dummies: only the enable-fall clear keeps them out of the page
    fill(10'h120, 16, 8'h40);
    cmp("erase index", 32'h0000_002f, {24'h00_0000, link.nv_addr_low});
    cmd(`NVW_CMD_PAGE_ER);
    fill(10'h120, 1, 8'h77);
    cmd(`NVW_CMD_PAGE_WR);
    for (int i = 0; i < 16; i++)
      mem_chk(10'h120 + 10'(i), (i == 0) ? 8'h77 : 8'h00);
    fill(10'h300, 1, 8'h99);
    cmd(`NVW_CMD_PAGE_WR);
    av(1'h1, `NVW_REG_STAT, 32'h0000_0000);
    cmp("refused bit", 32'h0000_0008, q & 32'h0000_0008);
    mem_chk(10'h300, 8'h00);
    end_of_test;
  end
  initial begin
    #(40 * 30000);
    n_errors++;
    end_of_test;
  end
endmodule : tb_data_eeprom_write_erase_ctrl
`default_nettype wire
